/* design/fgt_pkg.sv */
package fgt_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int            ADDR_W         = 12;
    localparam logic [11:0]   OFS_C2B        = 12'h363;
    localparam logic [11:0]   OFS_C3C        = 12'h364;
    localparam logic [11:0]   OFS_C3D        = 12'h365;
    localparam logic [11:0]   OFS_C4         = 12'h366;
    localparam logic [11:0]   OFS_C5         = 12'h367;
    localparam logic [11:0]   OFS_BASE       = 12'h363;
    localparam int            NUM_REGS       = 5;
    localparam int            IDX_C2B        = 0;
    localparam int            IDX_C3C        = 1;
    localparam int            IDX_C3D        = 2;
    localparam int            IDX_C4         = 3;
    localparam int            IDX_C5         = 4;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int            TRIM_W         = 5;
    localparam int            TRIM_LSB       = 0;
    localparam int            RSVD_LSB       = 5;
    localparam logic [2:0]    RSVD_VAL       = 3'h0;
    localparam logic [4:0]    TRIM_RST       = 5'h00;

    typedef struct packed {
        logic [4:0] core2_input_b_gain_trim;
        logic [4:0] core3_input_c_gain_trim;
        logic [4:0] core3_input_d_gain_trim;
        logic [4:0] core4_gain_trim;
        logic [4:0] core5_gain_trim;
    } fgt_trims_t;

endpackage

/* design/fgt_fuse_rom.sv */
// Fuse storage model: read data come out of a register
module fgt_fuse_rom #(
    parameter int   DEPTH = 5,
    parameter int   W     = 5,
    parameter logic [24:0] INIT = 25'h0
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [2:0]    raddr,
    output logic      [W-1:0]  rdata
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= '0;
        end else if (int'(raddr) < DEPTH) begin
            rdata <= INIT[int'(raddr)*W +: W];
        end else begin
            rdata <= '0;
        end
    end
endmodule

/* design/fgt_regs.sv */
module fgt_regs #(
    parameter logic [24:0] FUSE_INIT = 25'h0
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  core2_sel_b,
    input  wire logic                  core3_sel_d,
    output logic      [4:0]            core2_gain_trim,
    output logic      [4:0]            core3_gain_trim,
    output logic      [4:0]            core4_gain_trim,
    output logic      [4:0]            core5_gain_trim,
    output fgt_pkg::fgt_trims_t        trims,
    output logic                       fuse_load_done
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic [2:0] reg_index(input logic [31:0] a);
        logic [11:0] w;
        w = a[13:2];
        if (a[1:0] == 2'h0 && w >= fgt_pkg::OFS_BASE &&
            w < fgt_pkg::OFS_BASE + 12'(fgt_pkg::NUM_REGS)) begin
            reg_index = 3'(w - fgt_pkg::OFS_BASE);
        end else begin
            reg_index = 3'h7;
        end
    endfunction

    logic [2:0]  idx;
    logic        hit;
    logic        access;
    logic [4:0]  trim_q [fgt_pkg::NUM_REGS];
    logic [2:0]  load_ptr_q;
    logic        load_busy_q;
    logic        load_wr_q;
    logic [2:0]  load_idx_q;
    logic [4:0]  fuse_rdata;

    assign idx    = reg_index(paddr);
    assign hit    = (idx != 3'h7) && (paddr[31:14] == 18'h0);
    assign access = psel && penable && pready;

    // ------------------------------------------------------------
    // Fuse load after reset
    // ------------------------------------------------------------
    // Fuse values are streamed one per cycle; bus writes are held off until done
    fgt_fuse_rom #(
        .DEPTH (fgt_pkg::NUM_REGS),
        .W     (fgt_pkg::TRIM_W),
        .INIT  (FUSE_INIT)
    ) u_fuse (
        .pclk    (pclk),
        .presetn (presetn),
        .raddr   (load_ptr_q),
        .rdata   (fuse_rdata)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_ptr_q  <= 3'h0;
            load_busy_q <= 1'b1;
            load_wr_q   <= 1'b0;
            load_idx_q  <= 3'h0;
        end else begin
            load_wr_q  <= load_busy_q;
            load_idx_q <= load_ptr_q;
            if (load_busy_q) begin
                if (load_ptr_q == 3'(fgt_pkg::NUM_REGS - 1)) begin
                    load_busy_q <= 1'b0;
                end else begin
                    load_ptr_q <= load_ptr_q + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_load_done <= 1'b0;
        end else begin
            fuse_load_done <= !load_busy_q && !load_wr_q;
        end
    end

    // ------------------------------------------------------------
    // Trim storage
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < fgt_pkg::NUM_REGS; i++) begin
                trim_q[i] <= fgt_pkg::TRIM_RST;
            end
        end else if (load_wr_q) begin
            trim_q[load_idx_q] <= fuse_rdata;
        end else if (access && pwrite && hit && pstrb[0]) begin
            // Reserved bits 7:5 are not stored and read back as zero
            trim_q[idx] <= pwdata[fgt_pkg::TRIM_LSB +: fgt_pkg::TRIM_W];
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // Ready is held low while fuses load, stalling the first access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && penable && !pready && fuse_load_done;
            pslverr <= psel && penable && !pready && fuse_load_done && !hit;
            if (psel && penable && !pready && fuse_load_done && !pwrite && hit) begin
                prdata <= {24'h0, fgt_pkg::RSVD_VAL, trim_q[idx]};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Trim outputs to the cores
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core2_gain_trim <= fgt_pkg::TRIM_RST;
            core3_gain_trim <= fgt_pkg::TRIM_RST;
            core4_gain_trim <= fgt_pkg::TRIM_RST;
            core5_gain_trim <= fgt_pkg::TRIM_RST;
            trims           <= '0;
        end else begin
            // Input A trim for core 2 lives outside this bank; the input C/D split is muxed here by core3_sel_d
            core2_gain_trim <= core2_sel_b ? trim_q[fgt_pkg::IDX_C2B] : fgt_pkg::TRIM_RST;
            core3_gain_trim <= core3_sel_d ? trim_q[fgt_pkg::IDX_C3D]
                                           : trim_q[fgt_pkg::IDX_C3C];
            core4_gain_trim <= trim_q[fgt_pkg::IDX_C4];
            core5_gain_trim <= trim_q[fgt_pkg::IDX_C5];
            trims.core2_input_b_gain_trim <= trim_q[fgt_pkg::IDX_C2B];
            trims.core3_input_c_gain_trim <= trim_q[fgt_pkg::IDX_C3C];
            trims.core3_input_d_gain_trim <= trim_q[fgt_pkg::IDX_C3D];
            trims.core4_gain_trim         <= trim_q[fgt_pkg::IDX_C4];
            trims.core5_gain_trim         <= trim_q[fgt_pkg::IDX_C5];
        end
    end

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // Whole bank as one vector, so that an untouched bank is a single compare
    logic [24:0] trim_flat;

    assign trim_flat = {trim_q[fgt_pkg::IDX_C2B], trim_q[fgt_pkg::IDX_C3C], trim_q[fgt_pkg::IDX_C3D],
                        trim_q[fgt_pkg::IDX_C4], trim_q[fgt_pkg::IDX_C5]};

    // ------------------------------------------------------------
    // Checks: trims to the cores
    // ------------------------------------------------------------
    core4_follow_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        1 |=> core4_gain_trim == $past(trim_q[fgt_pkg::IDX_C4]))
        else $error("core 4 trim does not follow its register");
    core5_follow_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        1 |=> core5_gain_trim == $past(trim_q[fgt_pkg::IDX_C5]))
        else $error("core 5 trim does not follow its register");
    core3_input_d_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        core3_sel_d |=> core3_gain_trim == $past(trim_q[fgt_pkg::IDX_C3D]))
        else $error("core 3 input D trim not applied");
    core3_input_c_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !core3_sel_d |=> core3_gain_trim == $past(trim_q[fgt_pkg::IDX_C3C]))
        else $error("core 3 input C trim not applied");
    core2_input_b_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        core2_sel_b |=> core2_gain_trim == $past(trim_q[fgt_pkg::IDX_C2B]))
        else $error("core 2 input B trim not applied");
    core2_not_b_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !core2_sel_b |=> core2_gain_trim == fgt_pkg::TRIM_RST)
        else $error("core 2 trim not cleared off input B");

    // ------------------------------------------------------------
    // Checks: trim view
    // ------------------------------------------------------------
    view_c2b_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        1 |=> trims.core2_input_b_gain_trim == $past(trim_q[fgt_pkg::IDX_C2B]))
        else $error("core 2 input B trim view stale");
    view_c3c_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        1 |=> trims.core3_input_c_gain_trim == $past(trim_q[fgt_pkg::IDX_C3C]))
        else $error("core 3 input C trim view stale");
    view_c3d_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        1 |=> trims.core3_input_d_gain_trim == $past(trim_q[fgt_pkg::IDX_C3D]))
        else $error("core 3 input D trim view stale");
    view_c4_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        1 |=> trims.core4_gain_trim == $past(trim_q[fgt_pkg::IDX_C4]))
        else $error("core 4 trim view stale");
    view_c5_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        1 |=> trims.core5_gain_trim == $past(trim_q[fgt_pkg::IDX_C5]))
        else $error("core 5 trim view stale");

    // ------------------------------------------------------------
    // Checks: fuse load
    // ------------------------------------------------------------
    fuse_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(fuse_load_done) |->
            trim_q[fgt_pkg::IDX_C5] == FUSE_INIT[fgt_pkg::IDX_C5 * fgt_pkg::TRIM_W +: fgt_pkg::TRIM_W])
        else $error("fuse value not loaded");
    fuse_c2b_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(fuse_load_done) |->
            trim_q[fgt_pkg::IDX_C2B] == FUSE_INIT[fgt_pkg::IDX_C2B * fgt_pkg::TRIM_W +: fgt_pkg::TRIM_W])
        else $error("core 2 input B fuse value not loaded");
    fuse_c3c_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(fuse_load_done) |->
            trim_q[fgt_pkg::IDX_C3C] == FUSE_INIT[fgt_pkg::IDX_C3C * fgt_pkg::TRIM_W +: fgt_pkg::TRIM_W])
        else $error("core 3 input C fuse value not loaded");
    fuse_c3d_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(fuse_load_done) |->
            trim_q[fgt_pkg::IDX_C3D] == FUSE_INIT[fgt_pkg::IDX_C3D * fgt_pkg::TRIM_W +: fgt_pkg::TRIM_W])
        else $error("core 3 input D fuse value not loaded");
    fuse_c4_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(fuse_load_done) |->
            trim_q[fgt_pkg::IDX_C4] == FUSE_INIT[fgt_pkg::IDX_C4 * fgt_pkg::TRIM_W +: fgt_pkg::TRIM_W])
        else $error("core 4 fuse value not loaded");
    fuse_latency_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> ##[1:8] fuse_load_done)
        else $error("fuse load did not finish in time");
    load_done_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        fuse_load_done |=> fuse_load_done)
        else $error("fuse load done dropped without reset");
    load_stall_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !fuse_load_done |-> !pready)
        else $error("bus answered while fuses were loading");

    // ------------------------------------------------------------
    // Checks: bus writes
    // ------------------------------------------------------------
    write_store_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && hit && pstrb[0] && !load_wr_q |=>
            trim_q[$past(idx)] == $past(pwdata[4:0]))
        else $error("register write not stored");
    strobe_off_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && !pstrb[0] |=> $stable(trim_flat))
        else $error("write with lane 0 off changed a trim");
    unmapped_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && !hit |=> $stable(trim_flat))
        else $error("refused write changed a trim");
    read_no_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && !pwrite |=> $stable(trim_flat))
        else $error("read changed a trim");
    idle_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !access && !load_wr_q |=> $stable(trim_flat))
        else $error("trim changed without a write or fuse load");

    // ------------------------------------------------------------
    // Checks: bus answer
    // ------------------------------------------------------------
    read_rsvd_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:5] == 27'h0)
        else $error("reserved bits read nonzero");
    read_back_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready && !pwrite && hit |-> prdata[4:0] == trim_q[idx])
        else $error("read data does not match the trim");
    read_refused_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready && (pwrite || !hit) |-> prdata == 32'h0)
        else $error("read data not zero outside a mapped read");
    err_refused_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready && !hit |-> pslverr)
        else $error("unmapped access answered without error");
    err_pair_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error raised outside the answer cycle");
    ready_pulse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held longer than one cycle");

endmodule

/* tb/fgt_regs_tb.sv */
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module fgt_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Fuse contents are an arbitrary pattern, distinct per register
    localparam logic [24:0] FUSE = 25'h0b56d39;
    // Offsets are word indices, so the byte address is four times the offset
    localparam logic [31:0] BASE = {18'h0, fgt_pkg::OFS_BASE, 2'h0};

    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [31:0]         paddr;
    logic [31:0]         pwdata;
    logic [3:0]          pstrb;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                core2_sel_b;
    logic                core3_sel_d;
    logic [4:0]          core2_gain_trim;
    logic [4:0]          core3_gain_trim;
    logic [4:0]          core4_gain_trim;
    logic [4:0]          core5_gain_trim;
    fgt_pkg::fgt_trims_t trims;
    logic                fuse_load_done;
    logic [31:0]         rd;
    logic                err;
    int                  miscompares;
    int                  compares;
    int                  seed;
    int                  m[5];

    fgt_regs #(.FUSE_INIT(FUSE)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core2_sel_b(core2_sel_b), .core3_sel_d(core3_sel_d),
        .core2_gain_trim(core2_gain_trim), .core3_gain_trim(core3_gain_trim), .core4_gain_trim(core4_gain_trim),
        .core5_gain_trim(core5_gain_trim), .trims(trims), .fuse_load_done(fuse_load_done));

    always #2 pclk = ~pclk;

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset();
        int n;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) m[i] = (FUSE >> (5 * i)) & 31;
        n = 0;
        while (fuse_load_done !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        `CHK(fuse_load_done, 1'b1)
    endtask

    // Idle edge first, so psel is never driven twice in one time step
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        `CHK(pready, 1'b1)
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic check_reg(input int i);
        apb(1'b0, BASE + 4 * i, 32'h0, 4'h0);
        `CHK(rd, 32'(m[i]))
        `CHK(err, 1'b0)
    endtask

    task automatic check_outs(input logic b, input logic dsel);
        core2_sel_b <= b;
        core3_sel_d <= dsel;
        repeat (3) @(posedge pclk);
        #1;
        `CHK(core2_gain_trim, b ? 5'(m[0]) : 5'h00)
        `CHK(core3_gain_trim, 5'(dsel ? m[2] : m[1]))
        `CHK(core4_gain_trim, 5'(m[3]))
        `CHK(core5_gain_trim, 5'(m[4]))
        `CHK(trims, {5'(m[0]), 5'(m[1]), 5'(m[2]), 5'(m[3]), 5'(m[4])})
        @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int k;
        int v;
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 32'h0; pwdata = 32'h0; pstrb = 4'h0; core2_sel_b = 1'b0; core3_sel_d = 1'b0;
        miscompares = 0; compares = 0; seed = 32'h5f6c1c6d;
        do_reset();
        for (int i = 0; i < 5; i++) check_reg(i);
        check_outs(1'b1, 1'b0);
        check_outs(1'b0, 1'b1);
        repeat (25) begin
            k = $unsigned($random(seed)) % 5;
            v = $random(seed) & 31;
            apb(1'b1, BASE + 4 * k, 32'(v), 4'hf);
            `CHK(err, 1'b0)
            m[k] = v;
            check_reg(k);
            check_outs(1'($random(seed)), 1'($random(seed)));
        end
        // Byte lane 0 disabled: the write must leave the trim alone
        apb(1'b1, BASE, 32'(~m[0] & 31), 4'he);
        check_reg(0);
        // Unmapped and misaligned places answer with an error and change nothing
        apb(1'b1, BASE + 32'h14, 32'h1f, 4'hf);
        `CHK(err, 1'b1)
        apb(1'b0, BASE + 32'h14, 32'h0, 4'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        apb(1'b1, BASE + 32'h1, 32'h1f, 4'hf);
        `CHK(err, 1'b1)
        for (int i = 0; i < 5; i++) check_reg(i);
        // A second reset brings back the fuse values over the written ones
        do_reset();
        for (int i = 0; i < 5; i++) check_reg(i);
        check_outs(1'b1, 1'b1);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        stop_test();
    end
endmodule
